/* File: verif/fpec_array_model.sv */
// fpec_array_model: flash array answering each start with done
// assumes: done held until the next start, which the design accepts
`timescale 1ns/1ps
module fpec_array_model (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // request and completion
  input  wire fpec_pkg::fpec_req_t req_i,
  input  wire logic                slow_i,
  output logic                     done_o
);
  int cnt_r;
  // slow answers outlast the longest tick minimum at divisor 20
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r  <= 0;
      done_o <= 1'b0;
    end
    else if (req_i.start)
    begin
      cnt_r  <= slow_i ? 2000 : 2;
      done_o <= 1'b0;
    end
    else if (cnt_r != 0)
    begin
      cnt_r  <= cnt_r - 1;
      done_o <= (cnt_r == 1);
    end
  end
endmodule : fpec_array_model

/* File: verif/fpec_ctrl_properties.sv */
// fpec_ctrl_properties: bus and array-side timing checks
// assumes: bound to fpec_ctrl, one clock domain
`timescale 1ns/1ps
module fpec_ctrl_properties (
  // clock and reset
  input wire logic                MCLK_I,
  input wire logic                RST_B_I,
  // register bus
  input wire logic                AWVALID_I,
  input wire logic                AWREADY_O,
  input wire logic                WVALID_I,
  input wire logic                WREADY_O,
  input wire logic                BVALID_O,
  input wire logic                BREADY_I,
  input wire logic [7:0]          ARADDR_I,
  input wire logic                ARVALID_I,
  input wire logic                ARREADY_O,
  input wire logic [31:0]         RDATA_O,
  input wire logic [1:0]          RRESP_O,
  input wire logic                RVALID_O,
  input wire logic                RREADY_I,
  // array side
  input wire fpec_pkg::fpec_req_t ARRAY_REQ_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);
  // *********
  // bus
  // *********
  chk_aw_ready_drop: assert property (AWVALID_I && AWREADY_O |=> !AWREADY_O)
    else $error("write address ready stayed high");
  chk_write_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I &&
    WREADY_O |-> ##[1:2] BVALID_O) else $error("no write response");
  chk_bvalid_once: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
    else $error("write response repeated");
  chk_rvalid_once: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("read response repeated");
  chk_read_latency: assert property (ARVALID_I && ARREADY_O |-> ##2 RVALID_O)
    else $error("read answer not two cycles after address");
  chk_read_unmapped: assert property (ARVALID_I && ARREADY_O &&
    !(ARADDR_I inside {8'h00, 8'h04, 8'h08, 8'h24, 8'h30, 8'h34, 8'h38,
    8'h3C}) |-> ##2 (RRESP_O == 2'b10 && RDATA_O == 32'h0000_0000))
    else $error("unmapped read not refused");
  // *********
  // array
  // *********
  chk_start_spacing: assert property (ARRAY_REQ_O.start |=>
    !ARRAY_REQ_O.start [*8]) else $error("start while busy");
  chk_req_held: assert property (!ARRAY_REQ_O.start |->
    $stable(ARRAY_REQ_O.addr) && $stable(ARRAY_REQ_O.data))
    else $error("request fields moved without start");
  cover property (ARRAY_REQ_O.start &&
    ARRAY_REQ_O.op == fpec_pkg::FPEC_OP_WRITE);
  cover property (ARRAY_REQ_O.start &&
    ARRAY_REQ_O.op == fpec_pkg::FPEC_OP_PAGE);
  cover property (ARRAY_REQ_O.start &&
    ARRAY_REQ_O.op == fpec_pkg::FPEC_OP_MASS);
endmodule : fpec_ctrl_properties

bind fpec_ctrl fpec_ctrl_properties i_fpec_ctrl_properties (
  .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
  .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
  .ARRAY_REQ_O(ARRAY_REQ_O)
);

/* File: verif/fpec_ctrl_tb.sv */
// fpec_ctrl_tb: register tests of fpec_ctrl over AXI4-Lite
// assumes: array model in place of the flash array
`timescale 1ns/1ps
module fpec_ctrl_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        brdy = 1'b0;
  logic        arv = 1'b0;
  logic        rrdy = 1'b0;
  logic        rd_att = 1'b0;
  logic        slow = 1'b0;
  logic        awr, wrdy, bv, arr, rv, done, tick;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata;
  int          fail_count = 0;
  int          n_compared = 0;
  int          k;
  int          n_tick = 0;
  int          t0;
  fpec_pkg::fpec_req_t req;

  fpec_ctrl i_fpec_ctrl (.MCLK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awaddr),
    .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wdata), .WSTRB_I(4'hF),
    .WVALID_I(wv), .WREADY_O(wrdy), .BRESP_O(bresp), .BVALID_O(bv),
    .BREADY_I(brdy), .ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arr),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rrdy),
    .ARRAY_REQ_O(req), .ARRAY_DONE_I(done), .ARRAY_READ_I(rd_att),
    .TIMING_TICK_O(tick));
  fpec_array_model i_fpec_array_model (.clk_i(clk), .rst_b_i(rst_b),
    .req_i(req), .slow_i(slow), .done_o(done));

  initial
  begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (tick) n_tick <= n_tick + 1;
  end
  // *********
  // tasks
  // *********
  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      n++;
    end while (!(bv && brdy) && n < 200);
    resp = bresp;
    brdy <= 1'b0;
    if (n == 200) chk(32'h1, 32'h0);
    if (n == 200) end_of_test;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
    end while (!(rv && rrdy) && n < 200);
    d = rdata;
    resp = rresp;
    rrdy <= 1'b0;
    if (n == 200) chk(32'h1, 32'h0);
    if (n == 200) end_of_test;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rc

  // busy polling bounded well past the slowest answer
  task automatic idle;
    logic [31:0] d;
    for (int n = 0; n < 800; n++)
    begin
      rd(8'h08, d);
      if (d[24] === 1'b0) return;
    end
    chk(32'h1, 32'h0);
    end_of_test;
  endtask : idle
  // *********
  // sequence
  // *********
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rc(8'h00, 32'h1000_0000);
    rc(8'h04, 32'h0000_0078);
    rc(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h1000_123C);
    rc(8'h00, 32'h1000_123C);
    wr(8'h04, 32'h0000_0014);
    rc(8'h04, 32'h0000_0014);
    for (k = 0; k < 4; k++)
      wr(8'h30 + 8'(4 * k), 32'(32'h1111_1111 * (k + 1)));
    wr(8'h08, 32'h0000_0001);
    rc(8'h24, 32'h0000_0002);
    rc(8'h08, 32'h0000_0000);
    wr(8'h24, 32'h0000_0003);
    rc(8'h24, 32'h0000_0002);
    wr(8'h24, 32'h0000_0000);
    rc(8'h24, 32'h0000_0000);
    wr(8'h08, 32'h2000_0000);
    t0 = n_tick;
    wr(8'h08, 32'h2000_0001);
    rc(8'h08, 32'h2100_0001);
    @(posedge clk);
    rd_att <= 1'b1;
    repeat (4) @(posedge clk);
    rd_att <= 1'b0;
    rc(8'h24, 32'h0000_0002);
    wr(8'h24, 32'h0000_0000);
    wr(8'h00, 32'h1000_7770);
    rc(8'h24, 32'h0000_0002);
    idle;
    chk(n_tick - t0, 32'(fpec_pkg::WRITE_TICKS));
    rc(8'h00, 32'h1000_123C);
    rc(8'h24, 32'h0000_0003);
    rc(8'h08, 32'h2000_0000);
    chk(32'(req.op), 32'(fpec_pkg::FPEC_OP_WRITE));
    chk({4'h0, req.addr[31:4]}, 32'h0100_0123);
    for (k = 0; k < 4; k++)
      chk(req.data[32*k +: 32], 32'(32'h1111_1111 * (k + 1)));
    wr(8'h24, 32'h0000_0000);
    wr(8'h08, 32'h2000_AA04);
    rc(8'h24, 32'h0000_0002);
    wr(8'h24, 32'h0000_0000);
    t0 = n_tick;
    wr(8'h08, 32'h2200_5504);
    rc(8'h08, 32'h2300_5504);
    idle;
    chk(n_tick - t0, 32'(fpec_pkg::PAGE_TICKS));
    rc(8'h08, 32'h2200_0000);
    chk(32'(req.op), 32'(fpec_pkg::FPEC_OP_PAGE));
    chk(32'(req.lowv), 32'h0000_0001);
    slow <= 1'b1;
    wr(8'h08, 32'h2000_AA02);
    idle;
    rc(8'h08, 32'h2000_0000);
    chk(32'(req.op), 32'(fpec_pkg::FPEC_OP_MASS));
    wr(8'h24, 32'h0000_0000);
    wr(8'h08, 32'h2000_0004);
    rc(8'h24, 32'h0000_0002);
    wr(8'h24, 32'h0000_0000);
    wr(8'h08, 32'h3000_0000);
    wr(8'h08, 32'h3000_0001);
    rc(8'h24, 32'h0000_0002);
    wr(8'h10, 32'h0000_0001);
    chk(32'(resp), 32'h0000_0002);
    rc(8'h10, 32'h0000_0000);
    chk(32'(resp), 32'h0000_0002);
    end_of_test;
  end
endmodule : fpec_ctrl_tb

/* File: verilog/fpec_ctrl.sv */
// fpec_ctrl: flash program/erase control registers and sequencer
// assumes: RST_B_I is the power-on reset only; array acks with done held until the next start
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fpec_ctrl (
  // clock and power-on reset
  input  wire logic                MCLK_I,
  input  wire logic                RST_B_I,
  // axi4-lite write address and data
  input  wire logic [7:0]          AWADDR_I,
  input  wire logic                AWVALID_I,
  output logic                     AWREADY_O,
  input  wire logic [31:0]         WDATA_I,
  input  wire logic [3:0]          WSTRB_I,
  input  wire logic                WVALID_I,
  output logic                     WREADY_O,
  // axi4-lite write response
  output logic [1:0]               BRESP_O,
  output logic                     BVALID_O,
  input  wire logic                BREADY_I,
  // axi4-lite read
  input  wire logic [7:0]          ARADDR_I,
  input  wire logic                ARVALID_I,
  output logic                     ARREADY_O,
  output logic [31:0]              RDATA_O,
  output logic [1:0]               RRESP_O,
  output logic                     RVALID_O,
  input  wire logic                RREADY_I,
  // flash array side
  output fpec_pkg::fpec_req_t      ARRAY_REQ_O,
  input  wire logic                ARRAY_DONE_I,
  input  wire logic                ARRAY_READ_I,
  output logic                     TIMING_TICK_O
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {
    S_IDLE,
    S_RUN,
    S_FINISH
  } fpec_state_t;

  fpec_state_t      st_r, st_nxt;
  logic [31:0]      addr_r, addr_nxt;
  logic [7:0]       div_r, div_nxt;
  logic [3:0]       key_r, key_nxt;
  logic             lowv_r, lowv_nxt;
  logic [7:0]       ecode_r, ecode_nxt;
  logic             width_r, width_nxt;
  logic             page_r, page_nxt;
  logic             mass_r, mass_nxt;
  logic             wr_r, wr_nxt;
  logic             fail_r, fail_nxt;
  logic             done_r, done_nxt;
  logic [15:0]      tcnt_r, tcnt_nxt;
  fpec_pkg::fpec_op_t op_r, op_nxt;
  fpec_pkg::fpec_req_t req_nxt;

  // bus side
  logic             aw_r, w_r, aw_nxt, w_nxt;
  logic [7:0]       awa_r, awa_nxt;
  logic [31:0]      wd_r, wd_nxt;
  logic [3:0]       ws_r, ws_nxt;
  logic             bv_nxt, rv_nxt, rpend_r, rpend_nxt;
  logic [7:0]       ra_r, ra_nxt;
  logic [1:0]       rr_nxt, br_nxt;
  logic [31:0]      rd_nxt;

  logic             busy;
  logic             tick;
  logic             wr_fire;
  logic             stage_we;
  logic [31:0]      stage_rd;
  logic [127:0]     stage_all;
  logic [31:0]      ctrl_word;
  logic             arr_rd_q1, arr_rd_q2, arr_rd_q3;
  logic             arr_dn_q1, arr_dn_q2;

  assign busy = (st_r != S_IDLE);
  assign wr_fire = aw_r && w_r && !BVALID_O;
  assign stage_we = wr_fire && !busy
    && awa_r >= fpec_pkg::ADDR_DATA0 && awa_r <= fpec_pkg::ADDR_DATA3;

  // ************************************************************
  // helpers
  // ************************************************************
  fpec_tick u_tick (
    .clk_i   (MCLK_I),
    .rst_b_i (RST_B_I),
    .div_i   (div_r),
    .run_i   (st_r == S_RUN),
    .tick_o  (tick)
  );

  fpec_stage u_stage (
    .clk_i   (MCLK_I),
    .rst_b_i (RST_B_I),
    .we_i    (stage_we),
    .waddr_i (awa_r[3:2]),
    .wdata_i (wd_r),
    .wstrb_i (ws_r),
    .raddr_i (ARADDR_I[3:2]),
    .rdata_o (stage_rd),
    .all_o   (stage_all)
  );

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[fpec_pkg::KEY_HI:fpec_pkg::KEY_LO] = key_r;
    ctrl_word[fpec_pkg::LOWV_BIT] = lowv_r;
    ctrl_word[fpec_pkg::BUSY_BIT] = busy;
    ctrl_word[fpec_pkg::ECODE_HI:fpec_pkg::ECODE_LO] = ecode_r;
    ctrl_word[fpec_pkg::WIDTH_BIT] = width_r;
    ctrl_word[fpec_pkg::PAGE_BIT] = page_r;
    ctrl_word[fpec_pkg::MASS_BIT] = mass_r;
    ctrl_word[fpec_pkg::WRITE_BIT] = wr_r;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    st_nxt   = st_r;
    addr_nxt = addr_r;
    div_nxt  = div_r;
    key_nxt  = key_r;
    lowv_nxt = lowv_r;
    ecode_nxt = ecode_r;
    width_nxt = width_r;
    page_nxt = page_r;
    mass_nxt = mass_r;
    wr_nxt   = wr_r;
    fail_nxt = fail_r;
    done_nxt = done_r;
    tcnt_nxt = tcnt_r;
    op_nxt   = op_r;
    aw_nxt   = aw_r;
    w_nxt    = w_r;
    awa_nxt  = awa_r;
    wd_nxt   = wd_r;
    ws_nxt   = ws_r;
    bv_nxt   = BVALID_O;
    br_nxt   = BRESP_O;
    rv_nxt   = RVALID_O;
    rr_nxt   = RRESP_O;
    rd_nxt   = RDATA_O;
    rpend_nxt = 1'b0;
    ra_nxt   = ra_r;
    req_nxt  = ARRAY_REQ_O;
    req_nxt.start = 1'b0;

    if (AWVALID_I && AWREADY_O)
    begin
      aw_nxt  = 1'b1;
      awa_nxt = AWADDR_I;
    end
    if (WVALID_I && WREADY_O)
    begin
      w_nxt  = 1'b1;
      wd_nxt = WDATA_I;
      ws_nxt = WSTRB_I;
    end
    if (BVALID_O && BREADY_I)
    begin
      bv_nxt = 1'b0;
    end

    // flag register: write 0 clears, write 1 keeps
    if (wr_fire && awa_r == fpec_pkg::ADDR_FLAGS && ws_r[0])
    begin
      if (!wd_r[fpec_pkg::FAIL_BIT])
      begin
        fail_nxt = 1'b0;
      end
      if (!wd_r[fpec_pkg::DONE_BIT])
      begin
        done_nxt = 1'b0;
      end
    end

    if (wr_fire)
    begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = 2'b00;
      if (busy && awa_r != fpec_pkg::ADDR_FLAGS)
      begin
        fail_nxt = 1'b1;
      end
      else
      begin
        case (awa_r)
          fpec_pkg::ADDR_TARGET:
          begin
            for (int b = 0; b < 4; b++)
            begin
              if (ws_r[b])
              begin
                addr_nxt[8*b +: 8] = wd_r[8*b +: 8];
              end
            end
          end
          fpec_pkg::ADDR_DIVISOR:
          begin
            if (ws_r[0])
            begin
              div_nxt = wd_r[7:0];
            end
          end
          fpec_pkg::ADDR_CONTROL:
          begin
            if (ws_r[3])
            begin
              key_nxt = wd_r[fpec_pkg::KEY_HI:fpec_pkg::KEY_LO];
              lowv_nxt = wd_r[fpec_pkg::LOWV_BIT];
            end
            if (ws_r[1])
            begin
              ecode_nxt = wd_r[fpec_pkg::ECODE_HI:fpec_pkg::ECODE_LO];
            end
            if (ws_r[0])
            begin
              width_nxt = wd_r[fpec_pkg::WIDTH_BIT];
              // start bits: ones start, zeros ignored; key seen before
              if (wd_r[fpec_pkg::WRITE_BIT] || wd_r[fpec_pkg::PAGE_BIT]
                  || wd_r[fpec_pkg::MASS_BIT])
              begin
                if (key_r != fpec_pkg::KEY_UNLOCK)
                begin
                  fail_nxt = 1'b1;
                end
                else if (wd_r[fpec_pkg::MASS_BIT])
                begin
                  if (ecode_nxt == fpec_pkg::ECODE_MASS)
                  begin
                    mass_nxt = 1'b1;
                    op_nxt   = fpec_pkg::FPEC_OP_MASS;
                    st_nxt   = S_RUN;
                  end
                  else
                  begin
                    fail_nxt = 1'b1;
                  end
                end
                else if (wd_r[fpec_pkg::PAGE_BIT])
                begin
                  if (ecode_nxt == fpec_pkg::ECODE_PAGE)
                  begin
                    page_nxt = 1'b1;
                    op_nxt   = fpec_pkg::FPEC_OP_PAGE;
                    st_nxt   = S_RUN;
                  end
                  else
                  begin
                    fail_nxt = 1'b1;
                  end
                end
                else
                begin
                  wr_nxt = 1'b1;
                  op_nxt = fpec_pkg::FPEC_OP_WRITE;
                  st_nxt = S_RUN;
                end
              end
            end
          end
          fpec_pkg::ADDR_FLAGS:
          begin
          end
          default:
          begin
            if (!stage_we)
            begin
              br_nxt = 2'b10;
            end
          end
        endcase
      end
    end

    // reads: busy refuses array reads only
    if (busy && arr_rd_q2 && !arr_rd_q3)
    begin
      fail_nxt = 1'b1;
    end

    if (ARVALID_I && ARREADY_O)
    begin
      rpend_nxt = 1'b1;
      ra_nxt    = ARADDR_I;
    end
    if (rpend_r)
    begin
      rv_nxt = 1'b1;
      rr_nxt = 2'b00;
      case (ra_r)
        fpec_pkg::ADDR_TARGET:  rd_nxt = addr_r;
        fpec_pkg::ADDR_DIVISOR: rd_nxt = {24'h00_0000, div_r};
        fpec_pkg::ADDR_CONTROL: rd_nxt = ctrl_word;
        fpec_pkg::ADDR_FLAGS:   rd_nxt = {30'h0000_0000, fail_r, done_r};
        default:
        begin
          if (ra_r >= fpec_pkg::ADDR_DATA0 && ra_r <= fpec_pkg::ADDR_DATA3)
          begin
            rd_nxt = stage_rd;
          end
          else
          begin
            rd_nxt = 32'h0000_0000;
            rr_nxt = 2'b10;
          end
        end
      endcase
    end
    else if (RVALID_O && RREADY_I)
    begin
      rv_nxt = 1'b0;
    end

    // sequencer
    case (st_r)
      S_IDLE:
      begin
        if (st_nxt == S_RUN)
        begin
          tcnt_nxt = 16'h0000;
          req_nxt.start = 1'b1;
          req_nxt.op    = op_nxt;
          req_nxt.addr  = {addr_r[31:fpec_pkg::ALIGN_BITS],
                           {fpec_pkg::ALIGN_BITS{1'b0}}};
          req_nxt.data  = stage_all;
          req_nxt.lowv  = lowv_nxt;
        end
      end
      S_RUN:
      begin
        if (tick)
        begin
          tcnt_nxt = tcnt_r + 16'h0001;
        end
        // done waits for both the array ack and minimum paced time
        if (arr_dn_q2 && (tcnt_r >= (op_r == fpec_pkg::FPEC_OP_MASS ?
            fpec_pkg::MASS_TICKS : op_r == fpec_pkg::FPEC_OP_PAGE ?
            fpec_pkg::PAGE_TICKS : fpec_pkg::WRITE_TICKS)))
        begin
          st_nxt = S_FINISH;
        end
      end
      S_FINISH:
      begin
        wr_nxt   = 1'b0;
        page_nxt = 1'b0;
        mass_nxt = 1'b0;
        if (op_r != fpec_pkg::FPEC_OP_WRITE)
        begin
          ecode_nxt = fpec_pkg::ECODE_NONE;
        end
        done_nxt = 1'b1;
        st_nxt   = S_IDLE;
      end
      default:
      begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  // ************************************************************
  // registers, power-on reset only
  // ************************************************************
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      st_r    <= S_IDLE;
      addr_r  <= fpec_pkg::TARGET_RST;
      div_r   <= fpec_pkg::DIVISOR_RST;
      key_r   <= 4'h0;
      lowv_r  <= 1'b0;
      ecode_r <= 8'h00;
      width_r <= 1'b0;
      page_r  <= 1'b0;
      mass_r  <= 1'b0;
      wr_r    <= 1'b0;
      fail_r  <= 1'b0;
      done_r  <= 1'b0;
      tcnt_r  <= 16'h0000;
      op_r    <= fpec_pkg::FPEC_OP_WRITE;
      aw_r    <= 1'b0;
      w_r     <= 1'b0;
      awa_r   <= 8'h00;
      wd_r    <= 32'h0000_0000;
      ws_r    <= 4'h0;
      BVALID_O <= 1'b0;
      BRESP_O <= 2'b00;
      RVALID_O <= 1'b0;
      RRESP_O <= 2'b00;
      RDATA_O <= 32'h0000_0000;
      rpend_r <= 1'b0;
      ra_r    <= 8'h00;
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
      ARREADY_O <= 1'b0;
      ARRAY_REQ_O <= '0;
      TIMING_TICK_O <= 1'b0;
      arr_rd_q1 <= 1'b0;
      arr_rd_q2 <= 1'b0;
      arr_rd_q3 <= 1'b0;
      arr_dn_q1 <= 1'b0;
      arr_dn_q2 <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      addr_r  <= addr_nxt;
      div_r   <= div_nxt;
      key_r   <= key_nxt;
      lowv_r  <= lowv_nxt;
      ecode_r <= ecode_nxt;
      width_r <= width_nxt;
      page_r  <= page_nxt;
      mass_r  <= mass_nxt;
      wr_r    <= wr_nxt;
      fail_r  <= fail_nxt;
      done_r  <= done_nxt;
      tcnt_r  <= tcnt_nxt;
      op_r    <= op_nxt;
      aw_r    <= aw_nxt;
      w_r     <= w_nxt;
      awa_r   <= awa_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      BVALID_O <= bv_nxt;
      BRESP_O <= br_nxt;
      RVALID_O <= rv_nxt;
      RRESP_O <= rr_nxt;
      RDATA_O <= rd_nxt;
      rpend_r <= rpend_nxt;
      ra_r    <= ra_nxt;
      AWREADY_O <= !aw_nxt && !bv_nxt && !(AWVALID_I && AWREADY_O);
      WREADY_O <= !w_nxt && !bv_nxt && !(WVALID_I && WREADY_O);
      ARREADY_O <= !rv_nxt && !rpend_nxt && !(ARVALID_I && ARREADY_O);
      ARRAY_REQ_O <= req_nxt;
      TIMING_TICK_O <= tick;
      arr_rd_q1 <= ARRAY_READ_I;
      arr_rd_q2 <= arr_rd_q1;
      arr_rd_q3 <= arr_rd_q2;
      arr_dn_q1 <= ARRAY_DONE_I;
      arr_dn_q2 <= arr_dn_q1;
    end
  end

endmodule : fpec_ctrl

/* File: verilog/fpec_pkg.sv */
// fpec_pkg: constants and carrier types of the flash program/erase control
// assumes: one 20 MHz system clock, AXI4-Lite register access
package fpec_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0]  ADDR_TARGET    = 8'h00;
  localparam logic [7:0]  ADDR_DIVISOR   = 8'h04;
  localparam logic [7:0]  ADDR_CONTROL   = 8'h08;
  localparam logic [7:0]  ADDR_FLAGS     = 8'h24;
  localparam logic [7:0]  ADDR_DATA0     = 8'h30;
  localparam logic [7:0]  ADDR_DATA3     = 8'h3C;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] TARGET_RST     = 32'h1000_0000;
  localparam logic [7:0]  DIVISOR_RST    = 8'h78;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int          KEY_HI         = 31;
  localparam int          KEY_LO         = 28;
  localparam logic [3:0]  KEY_UNLOCK     = 4'h2;
  localparam int          LOWV_BIT       = 25;
  localparam int          BUSY_BIT       = 24;
  localparam int          ECODE_HI       = 15;
  localparam int          ECODE_LO       = 8;
  localparam logic [7:0]  ECODE_NONE     = 8'h00;
  localparam logic [7:0]  ECODE_PAGE     = 8'h55;
  localparam logic [7:0]  ECODE_MASS     = 8'hAA;
  localparam int          WIDTH_BIT      = 4;
  localparam int          PAGE_BIT       = 2;
  localparam int          MASS_BIT       = 1;
  localparam int          WRITE_BIT      = 0;
  localparam int          FAIL_BIT       = 1;
  localparam int          DONE_BIT       = 0;
  localparam int          ALIGN_BITS     = 4;

  // ************************************************************
  // timing in ticks of the 1 MHz timing clock
  // ************************************************************
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          TIMING_HZ      = 1_000_000;
  localparam logic [15:0] WRITE_TICKS    = 16'h0014;
  localparam logic [15:0] PAGE_TICKS     = 16'h0028;
  localparam logic [15:0] MASS_TICKS     = 16'h0050;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    FPEC_OP_WRITE,
    FPEC_OP_PAGE,
    FPEC_OP_MASS
  } fpec_op_t;

  typedef struct packed {
    logic          start;
    fpec_op_t      op;
    logic [31:0]   addr;
    logic [127:0]  data;
    logic          lowv;
  } fpec_req_t;

endpackage : fpec_pkg

/* File: verilog/fpec_stage.sv */
// fpec_stage: four staged write data words, registered read port
// assumes: writer and reader on the same clock
`timescale 1ns/1ps
module fpec_stage (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // write port
  input  wire logic         we_i,
  input  wire logic [1:0]   waddr_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic [3:0]   wstrb_i,
  // read port
  input  wire logic [1:0]   raddr_i,
  output logic      [31:0]  rdata_o,
  output logic      [127:0] all_o
);

  logic [31:0] mem_r [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_word
      always_ff @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          mem_r[g] <= 32'h0000_0000;
        end
        else if (we_i && waddr_i == 2'(g))
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wstrb_i[b])
            begin
              mem_r[g][8*b +: 8] <= wdata_i[8*b +: 8];
            end
          end
        end
      end
      assign all_o[32*g +: 32] = mem_r[g];
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= 32'h0000_0000;
    end
    else
    begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule : fpec_stage

/* File: verilog/fpec_tick.sv */
// fpec_tick: divides the system clock into a one-cycle timing enable
// assumes: divisor is held steady while operations run
`timescale 1ns/1ps
module fpec_tick (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // control
  input  wire logic [7:0]  div_i,
  input  wire logic        run_i,
  // enable out
  output logic             tick_o
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       tick_nxt;

  always_comb
  begin
    cnt_nxt  = 8'h00;
    tick_nxt = 1'b0;
    // divisor 0 or 1 treated as every cycle
    if (run_i)
    begin
      if (cnt_r + 8'h01 >= div_i)
      begin
        tick_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r  <= 8'h00;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end

endmodule : fpec_tick
